// *** pkg/ddc_cfg.svh ***
// Constants of the DDR input capture block: offsets, fields, resets, counts
`ifndef DDC_CFG_SVH
`define DDC_CFG_SVH
`define DDC_DATA_W 8
`define DDC_ADDR_W 12
`define DDC_CTRL_OFFSET 12'h000
`define DDC_PAIR_OFFSET 12'h004
`define DDC_SDR_OFFSET 12'h008
`define DDC_COUNT_OFFSET 12'h00c
`define DDC_CTRL_W 5
`define DDC_CTRL_RESET 5'h18
`define DDC_BIT_DDR 0
`define DDC_BIT_POL 1
`define DDC_BIT_DELAY 2
`define DDC_BIT_SYNCCE 3
`define DDC_BIT_SDRCE 4
`define DDC_DELAY_STAGES 1
`define DDC_COUNT_W 16
`endif

// *** pkg/ddc_pkg.sv ***
// Types of the DDR input capture block
`include "ddc_cfg.svh"
package ddc_pkg;
	typedef struct packed {
		logic sdrCe;
		logic syncCe;
		logic delayEnable;
		logic syncClockPolaritySelect;
		logic ddrMode;
	} ddc_ctrl_type;
	typedef struct packed {
		logic [`DDC_DATA_W-1:0] fallEdgeStream;
		logic [`DDC_DATA_W-1:0] riseEdgeStream;
	} ddc_pair_type;
endpackage : ddc_pkg

// *** logic/ddc_sync2.sv ***
// Two-stage register with reset and enable, on either clock edge
`timescale 1ns/10ps
module ddc_sync2 #(
	parameter int W   = 1,
	parameter bit NEG = 1'b0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Data
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage;

	generate
		if (NEG) begin : g_neg
			always_ff @(negedge clk or posedge reset) begin
				if (reset) begin
					stage <= '0;
					q     <= '0;
				end else if (ce) begin
					stage <= d;
					q     <= stage;
				end
			end
		end else begin : g_pos
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					stage <= '0;
					q     <= '0;
				end else if (ce) begin
					stage <= d;
					q     <= stage;
				end
			end
		end
	endgenerate
endmodule : ddc_sync2

// *** logic/ddc_delay.sv ***
// Selectable register delay line on the single-rate input path
`timescale 1ns/10ps
module ddc_delay #(
	parameter int W      = 8,
	parameter int STAGES = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Data
	input  wire logic         enable,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] taps [STAGES];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < STAGES; i++) begin
				taps[i] <= '0;
			end
		end else begin
			taps[0] <= d;
			for (int i = 1; i < STAGES; i++) begin
				taps[i] <= taps[i-1];
			end
		end
	end

	assign q = enable ? taps[STAGES-1] : d;
endmodule : ddc_delay

// *** logic/ddc_top.sv ***
// DDR/SDR input capture register block with APB control
`timescale 1ns/10ps
`include "ddc_cfg.svh"
module ddc_top #(
	parameter int W      = `DDC_DATA_W,
	parameter int STAGES = `DDC_DELAY_STAGES
) (
	// System clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	// Strobe domain from the pad
	input  wire logic                   dqsClk,
	input  wire logic [W-1:0]           padData,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`DDC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Core side
	output logic      [W-1:0]           sdrData,
	output logic                        sdrValid,
	output logic      [W-1:0]           riseEdgeStream,
	output logic      [W-1:0]           fallEdgeStream,
	output logic                        ddrValid
);
	ddc_pkg::ddc_ctrl_type ctrl;
	logic [W-1:0]          riseCap;
	logic [W-1:0]          pairRise;
	logic [W-1:0]          pairFall;
	logic                  linkToggle;
	logic                  togglePos;
	logic                  toggleNeg;
	logic                  toggleSel;
	logic                  toggleSeen;
	logic                  newPair;
	logic [W-1:0]          syncedPad;
	logic [W-1:0]          delayedPad;
	logic [`DDC_COUNT_W-1:0] pairCount;
	logic                  apbAccess;
	logic                  addrHit;
	logic [31:0]           next_prdata;

	// Strobe domain: rising sample, then falling sample closes a pair
	always_ff @(posedge dqsClk or posedge reset) begin
		if (reset) begin
			riseCap <= '0;
		end else begin
			riseCap <= padData;
		end
	end

	// Pair held stable a full strobe period while the toggle crosses
	always_ff @(negedge dqsClk or posedge reset) begin
		if (reset) begin
			pairRise   <= '0;
			pairFall   <= '0;
			linkToggle <= 1'b0;
		end else begin
			pairRise   <= riseCap;
			pairFall   <= padData;
			linkToggle <= ~linkToggle;
		end
	end

	// Toggle synchronisers on both system edges, with enable
	ddc_sync2 #(
		.W   (1),
		.NEG (1'b0)
	) u_sync_pos (
		.clk   (clk_sys),
		.reset (reset),
		.ce    (ctrl.syncCe),
		.d     (linkToggle),
		.q     (togglePos)
	);

	ddc_sync2 #(
		.W   (1),
		.NEG (1'b1)
	) u_sync_neg (
		.clk   (clk_sys),
		.reset (reset),
		.ce    (ctrl.syncCe),
		.d     (linkToggle),
		.q     (toggleNeg)
	);

	// Falling-edge path wins half a cycle of margin against strobe skew
	assign toggleSel = ctrl.syncClockPolaritySelect ? toggleNeg : togglePos;
	assign newPair   = toggleSel ^ toggleSeen;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			toggleSeen <= 1'b0;
		end else begin
			toggleSeen <= toggleSel;
		end
	end

	// Both streams leave on the same rising system edge
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			riseEdgeStream <= '0;
			fallEdgeStream <= '0;
			ddrValid       <= 1'b0;
		end else begin
			ddrValid <= newPair && ctrl.ddrMode;
			if (newPair && ctrl.ddrMode) begin
				riseEdgeStream <= pairRise;
				fallEdgeStream <= pairFall;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pairCount <= '0;
		end else if (ddrValid) begin
			pairCount <= pairCount + 1'b1;
		end
	end

	// Single-rate path: pin passes two flops, then optional delay
	ddc_sync2 #(
		.W   (W),
		.NEG (1'b0)
	) u_sync_pad (
		.clk   (clk_sys),
		.reset (reset),
		.ce    (ctrl.sdrCe),
		.d     (padData),
		.q     (syncedPad)
	);

	ddc_delay #(
		.W      (W),
		.STAGES (STAGES)
	) u_delay (
		.clk    (clk_sys),
		.reset  (reset),
		.enable (ctrl.delayEnable),
		.d      (syncedPad),
		.q      (delayedPad)
	);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sdrData  <= '0;
			sdrValid <= 1'b0;
		end else begin
			sdrValid <= !ctrl.ddrMode && ctrl.sdrCe;
			if (!ctrl.ddrMode && ctrl.sdrCe) begin
				sdrData <= delayedPad;
			end
		end
	end

	// APB slave: zero wait states, error on unmapped address
	assign apbAccess = psel && penable;
	assign pready    = 1'b1;
	assign addrHit   = (paddr == `DDC_CTRL_OFFSET) || (paddr == `DDC_PAIR_OFFSET) ||
	                   (paddr == `DDC_SDR_OFFSET) || (paddr == `DDC_COUNT_OFFSET);
	assign pslverr   = apbAccess && !addrHit;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl <= ddc_pkg::ddc_ctrl_type'(`DDC_CTRL_RESET);
		end else if (apbAccess && pwrite && paddr == `DDC_CTRL_OFFSET) begin
			ctrl <= ddc_pkg::ddc_ctrl_type'(pwdata[`DDC_CTRL_W-1:0]);
		end
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			`DDC_CTRL_OFFSET:  next_prdata[`DDC_CTRL_W-1:0] = ctrl;
			`DDC_PAIR_OFFSET:  next_prdata[2*W-1:0] = {fallEdgeStream, riseEdgeStream};
			`DDC_SDR_OFFSET:   next_prdata[W-1:0] = sdrData;
			`DDC_COUNT_OFFSET: next_prdata[`DDC_COUNT_W-1:0] = pairCount;
			default:           next_prdata = 32'h0000_0000;
		endcase
	end

	assign prdata = next_prdata;

	// Checks
	a_sdr_capture_enable: assert property (@(posedge clk_sys) disable iff (reset)
		$changed(sdrData) |-> $past(!ctrl.ddrMode && ctrl.sdrCe))
		else $error("single-rate data changed without single-rate enable");

	a_ddr_pair_source: assert property (@(posedge clk_sys) disable iff (reset)
		ddrValid |-> riseEdgeStream == $past(pairRise) && fallEdgeStream == $past(pairFall))
		else $error("double-rate streams do not match the captured pair");

	a_ddr_mode_only: assert property (@(posedge clk_sys) disable iff (reset)
		ddrValid |-> $past(ctrl.ddrMode) && $past(newPair))
		else $error("double-rate output without a new pair in double-rate mode");

	a_sync_ce_hold: assert property (@(posedge clk_sys) disable iff (reset)
		(!ctrl.syncCe)[*3] |-> !ddrValid)
		else $error("pair delivered while sync enable is low");

	a_pair_one_pulse: assert property (@(posedge clk_sys) disable iff (reset)
		newPair && ctrl.ddrMode |=> ddrValid ##1 !ddrValid)
		else $error("accepted pair did not give exactly one pulse");

	a_delay_path: assert property (@(posedge clk_sys) disable iff (reset)
		ctrl.delayEnable && $past(ctrl.delayEnable) && STAGES == 1 |-> delayedPad == $past(syncedPad))
		else $error("enabled input delay is not one stage");

	a_delay_bypass: assert property (@(posedge clk_sys) disable iff (reset)
		!ctrl.delayEnable |-> delayedPad == syncedPad)
		else $error("bypassed input delay still delays");

	a_streams_aligned: assert property (@(posedge clk_sys) disable iff (reset)
		$changed(riseEdgeStream) || $changed(fallEdgeStream) |-> ddrValid)
		else $error("a stream moved outside a pair delivery");

	a_count_follows: assert property (@(posedge clk_sys) disable iff (reset)
		ddrValid |=> pairCount == $past(pairCount) + 1'b1)
		else $error("pair counter missed a pair");

	c_ddr_rising: cover property (@(posedge clk_sys) disable iff (reset)
		ddrValid && !ctrl.syncClockPolaritySelect);
	c_ddr_falling: cover property (@(posedge clk_sys) disable iff (reset)
		ddrValid && ctrl.syncClockPolaritySelect);
	c_sdr_delayed: cover property (@(posedge clk_sys) disable iff (reset)
		sdrValid && ctrl.delayEnable);
	c_apb_error: cover property (@(posedge clk_sys) disable iff (reset)
		pslverr);
endmodule : ddc_top

// *** tb/ddc_mem_model.sv ***
// Behavioural model of the external memory driving strobe and pad data
`timescale 1ns/10ps
module ddc_mem_model (
	// Pad side
	output logic       dqsClk,
	output logic [7:0] padData
);
	initial begin
		dqsClk  = 1'b0;
		padData = 8'h00;
	end

	// Single-rate level on the pad
	task put(input logic [7:0] v);
		padData <= v;
	endtask : put

	// One strobe period of 30 ns; strobe stands low outside bursts
	// Edges kept off both system clock edges so the strobe phase is unrelated
	task burst(input logic [7:0] r, input logic [7:0] f);
		#1 padData = r;
		#4 dqsClk = 1'b1;
		#6 padData = f;
		#8 dqsClk = 1'b0;
		// Hold over: no stale value left on the pad
		#6 padData = ~f;
		#5;
	endtask : burst
endmodule : ddc_mem_model

// *** tb/ddc_top_tb.sv ***
// Self-checking bench of the DDR input capture block
`timescale 1ns/10ps
module ddc_top_tb;
	logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr;
	logic        dqsClk, sdrValid, ddrValid, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  padData, sdrData, riseEdgeStream, fallEdgeStream;
	int          mismatches, checked, n0, n1;

	ddc_top u_ddc_top (.clk_sys(clk_sys), .reset(reset), .dqsClk(dqsClk), .padData(padData),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sdrData(sdrData),
		.sdrValid(sdrValid), .riseEdgeStream(riseEdgeStream), .fallEdgeStream(fallEdgeStream),
		.ddrValid(ddrValid));
	ddc_mem_model u_ddc_mem_model (.dqsClk(dqsClk), .padData(padData));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task print_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			print_verdict();
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Edges until the single-rate output shows v
	task sdr_latency(input logic [7:0] v, output int n);
		@(posedge clk_sys);
		u_ddc_mem_model.put(v);
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (sdrData !== v && n < 20);
		if (n >= 20) begin
			mismatches++;
			print_verdict();
		end
	endtask : sdr_latency

	// One strobe pair, then the pulse on the core side
	task pair_test(input logic [7:0] r, input logic [7:0] f, input logic expect_pair);
		int n;
		n = 0;
		// Watch while the strobe runs: the pulse starts before the burst ends
		fork
			u_ddc_mem_model.burst(r, f);
			do begin
				@(posedge clk_sys);
				#1;
				n++;
			end while (ddrValid !== 1'b1 && n < 20);
		join
		check(n < 20, expect_pair);
		if (expect_pair && n >= 20) print_verdict();
		if (expect_pair) begin
			check(riseEdgeStream, r);
			check(fallEdgeStream, f);
			@(posedge clk_sys);
			#1;
			check(ddrValid, 1'b0);
		end
	endtask : pair_test

	task test_regs;
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h18);
		apb(1'b0, 12'h010, 32'h0);
		check(err, 1'b1);
		$display("register test done");
	endtask : test_regs

	task test_sdr;
		sdr_latency(8'h5a, n0);
		check(n0, 32'd3);
		check(sdrValid, 1'b1);
		apb(1'b1, 12'h000, 32'h1c);
		sdr_latency(8'ha5, n1);
		check(n1, 32'd4);
		check(n1, n0 + 1);
		apb(1'b1, 12'h000, 32'h08);
		@(posedge clk_sys);
		u_ddc_mem_model.put(8'h33);
		repeat (8) @(posedge clk_sys);
		#1;
		check(sdrData, 8'ha5);
		check(sdrValid, 1'b0);
		$display("single-rate test done");
	endtask : test_sdr

	task test_ddr;
		apb(1'b1, 12'h000, 32'h19);
		pair_test(8'h12, 8'hed, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'hed12);
		apb(1'b1, 12'h000, 32'h1b);
		pair_test(8'hc3, 8'h3c, 1'b1);
		apb(1'b1, 12'h000, 32'h11);
		pair_test(8'h77, 8'h88, 1'b0);
		check(riseEdgeStream, 8'hc3);
		apb(1'b0, 12'h00c, 32'h0);
		check(rd, 32'h2);
		$display("double-rate test done");
	endtask : test_ddr

	initial begin
		mismatches = 0;
		checked    = 0;
		reset      = 1'b1;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 12'h000;
		pwdata     = 32'h0;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		test_regs();
		test_sdr();
		test_ddr();
		print_verdict();
	end
endmodule : ddc_top_tb
